// ### shared/sbs_pkg.sv
// Constants, types and encodings for the strap latch and boot selector.
// Assumes one 20 MHz clock and a synchronous, active-low power-down reset.
package sbs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int unsigned CLK_HZ = 20000000; // Core clock rate
  localparam int unsigned HOLD_MS = 3; // Strap hold after enable rises
  localparam int unsigned SETUP_MS = 0; // Strap setup before enable rises
  // Least time, rounded up, at least one cycle
  localparam int unsigned HOLD_CYCLES_RAW = (HOLD_MS * CLK_HZ + 999) / 1000;
  localparam int unsigned HOLD_CYCLES = (HOLD_CYCLES_RAW < 1) ? 1 : HOLD_CYCLES_RAW;
  localparam int unsigned SYNC_STAGES = 3; // Pin synchroniser depth

  ////////////////////////////////////////////////////////////////////////////
  // Strap value field positions
  localparam int unsigned STRAP_PRINT_BIT = 0; // Print-select strap
  localparam int unsigned STRAP_BOOT_BIT = 1; // Boot-select strap
  localparam int unsigned STRAP_W = 2; // Field width

  ////////////////////////////////////////////////////////////////////////////
  // Fuse policy encodings
  localparam logic [1:0] LOG_ALWAYS = 2'h0; // Default: print
  localparam logic [1:0] LOG_ON_LOW = 2'h1; // Print when bit is 0
  localparam logic [1:0] LOG_ON_HIGH = 2'h2; // Print when bit is 1
  localparam logic [1:0] LOG_NEVER = 2'h3; // Never print

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [1:0] STRAP_RESET = 2'h0; // Held bits when powered off
  localparam logic PULL_UP_RESET = 1'b1; // Boot pin pull-up default
  localparam logic PIN_RESET = 1'b0; // Pin drive and input default

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [2:0] {
    ST_OFF = 3'b001, // Chip powered off
    ST_HOLD = 3'b010, // Reset in progress, pins sampled
    ST_RUN = 3'b100 // Pins released
  } sbs_state_t;

  typedef struct packed {
    logic por; // Power-on reset
    logic rtc_wdt; // RTC watchdog reset
    logic brownout; // Brownout reset
    logic other; // Any other reset
  } sbs_reset_cause_t;

  typedef struct packed {
    logic boot_select; // Bit STRAP_BOOT_BIT
    logic print_select; // Bit STRAP_PRINT_BIT
  } sbs_strap_t;

  typedef struct packed {
    logic flash_boot; // Boot from SPI flash
    logic download_boot; // Download boot
    logic invalid; // Both straps low
    logic log_enable; // Boot messages printed
  } sbs_boot_t;

endpackage

// ### rtl/sbs_pin_sync.sv
// Three-stage synchroniser for one pin with agreement filter.
// Assumes the pin is asynchronous to i_clk.
`timescale 1ns/1ps
module sbs_pin_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_pin,
  output logic o_level
);

  ////////////////////////////////////////////////////////////////////////////
  logic meta; // First stage, read only by the second
  logic stage2; // Second stage
  logic stage3; // Third stage
  logic next_level; // Filtered level next value

  // Change counts once stages two and three agree
  always_comb begin
    next_level = o_level;
    if (stage2 == stage3) begin
      next_level = stage3;
    end
  end

  // Stages and filtered level
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      meta <= RESET_VAL;
      stage2 <= RESET_VAL;
      stage3 <= RESET_VAL;
      o_level <= RESET_VAL;
    end else begin
      meta <= i_pin;
      stage2 <= meta;
      stage3 <= stage2;
      o_level <= next_level;
    end
  end

endmodule

// ### rtl/sbs_boot_decode.sv
// Decodes held strap bits and the fuse policy into boot choices.
// Pure combinational; the caller registers the result.
`timescale 1ns/1ps
module sbs_boot_decode (
  input wire sbs_pkg::sbs_strap_t i_strap,
  input wire logic [1:0] i_policy,
  output sbs_pkg::sbs_boot_t o_boot
);

  ////////////////////////////////////////////////////////////////////////////
  // Boot source and message policy
  always_comb begin
    o_boot = '0;
    // Boot bit high selects flash, print bit ignored
    o_boot.flash_boot = i_strap.boot_select;
    o_boot.download_boot = !i_strap.boot_select && i_strap.print_select;
    // Both low is a forbidden strap combination
    o_boot.invalid = !i_strap.boot_select && !i_strap.print_select;
    if (i_policy == sbs_pkg::LOG_ALWAYS) begin
      o_boot.log_enable = 1'b1;
    end else if (i_policy == sbs_pkg::LOG_ON_LOW) begin
      o_boot.log_enable = !i_strap.print_select;
    end else if (i_policy == sbs_pkg::LOG_ON_HIGH) begin
      o_boot.log_enable = i_strap.print_select;
    end else begin
      o_boot.log_enable = 1'b0;
    end
  end

endmodule

// ### rtl/sbs_strap_latch.sv
// Strap latch and boot selector top level.
// Samples both strap pins at qualifying resets, holds them until the
// chip enable falls, decodes boot source and message policy, and hands
// the pins to their ordinary functions once reset is over.
// Assumes i_reset_cause and the fuse field come from the i_clk domain;
// the pins and the enable pin are asynchronous and are synchronised.
`timescale 1ns/1ps
module sbs_strap_latch #(
  parameter int unsigned HOLD_CYCLES = sbs_pkg::HOLD_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_chip_enable,
  input wire sbs_pkg::sbs_reset_cause_t i_reset_cause,
  input wire logic [1:0] i_boot_log_policy_fuse,
  input wire logic i_print_select_strap_pin_in,
  input wire logic i_boot_select_strap_pin_in,
  input wire logic [1:0] i_func_out,
  input wire logic [1:0] i_func_oe,
  input wire logic i_func_boot_pull_up,
  output logic o_print_select_strap_pin_out,
  output logic o_print_select_strap_pin_oe,
  output logic o_boot_select_strap_pin_out,
  output logic o_boot_select_strap_pin_oe,
  output logic o_boot_select_pull_up,
  output logic [1:0] o_func_in,
  output logic o_chip_on,
  output logic o_pins_released,
  output logic o_strap_valid,
  output sbs_pkg::sbs_strap_t o_strap_capture_register,
  output sbs_pkg::sbs_boot_t o_boot
);

  ////////////////////////////////////////////////////////////////////////////
  // Parameter check
  localparam int unsigned CNT_W = $clog2(HOLD_CYCLES + 1);

  // Elaboration-time refusal of a hold count the counter cannot serve
  if (HOLD_CYCLES < 1) begin : g_hold_check
    $error("HOLD_CYCLES must be at least one");
  end

  localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(HOLD_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Synchronised pins
  logic en_level; // Chip enable after filtering
  logic print_level; // Print-select pin after filtering
  logic boot_level; // Boot-select pin after filtering

  // Enable pin, off until seen high
  sbs_pin_sync #(
    .RESET_VAL(1'b0)
  ) u_en_sync (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_pin(i_chip_enable),
    .o_level(en_level)
  );

  // Print-select strap pin
  sbs_pin_sync #(
    .RESET_VAL(1'b0)
  ) u_print_sync (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_pin(i_print_select_strap_pin_in),
    .o_level(print_level)
  );

  // Boot-select strap pin, pulled high by default
  sbs_pin_sync #(
    .RESET_VAL(1'b1)
  ) u_boot_sync (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_pin(i_boot_select_strap_pin_in),
    .o_level(boot_level)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer state
  sbs_pkg::sbs_state_t state; // Power and reset phase
  sbs_pkg::sbs_state_t next_state;
  logic [CNT_W-1:0] hold_cnt; // Cycles since enable or reset event
  logic [CNT_W-1:0] next_hold_cnt;
  sbs_pkg::sbs_strap_t strap; // Held strap bits
  sbs_pkg::sbs_strap_t next_strap;
  logic valid; // Strap bits captured since power-on
  logic next_valid;
  logic resample; // Capturing reset cause present, in hold or run

  // Only power-on, watchdog and brownout resets re-sample
  assign resample = i_reset_cause.por || i_reset_cause.rtc_wdt
                    || i_reset_cause.brownout;

  // Next state, hold count and strap latch
  always_comb begin
    next_state = state;
    next_hold_cnt = hold_cnt;
    next_strap = strap;
    next_valid = valid;
    case (state)
      sbs_pkg::ST_OFF: begin
        // Powered off: nothing is held
        next_strap = sbs_pkg::STRAP_RESET;
        next_valid = 1'b0;
        next_hold_cnt = '0;
        if (en_level) begin
          // Enable high powers the chip up
          next_state = sbs_pkg::ST_HOLD;
        end
      end
      sbs_pkg::ST_HOLD: begin
        if (!en_level) begin
          // Enable low powers off at once
          next_state = sbs_pkg::ST_OFF;
        end else if (resample) begin
          // A fresh capturing reset restarts the hold
          next_hold_cnt = '0;
        end else if (hold_cnt == HOLD_LAST) begin
          // Sample at the end of the hold time
          next_strap.print_select = print_level;
          next_strap.boot_select = boot_level;
          next_valid = 1'b1;
          next_state = sbs_pkg::ST_RUN;
        end else begin
          next_hold_cnt = hold_cnt + 1'b1;
        end
      end
      sbs_pkg::ST_RUN: begin
        if (!en_level) begin
          next_state = sbs_pkg::ST_OFF;
        end else if (resample) begin
          // Power-on, watchdog or brownout reset samples again
          next_hold_cnt = '0;
          next_state = sbs_pkg::ST_HOLD;
        end
        // Other resets leave the held bits alone
      end
      default: begin
        next_state = sbs_pkg::ST_OFF;
        next_hold_cnt = '0;
        next_strap = sbs_pkg::STRAP_RESET;
        next_valid = 1'b0;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      state <= sbs_pkg::ST_OFF;
      hold_cnt <= '0;
      strap <= sbs_pkg::STRAP_RESET;
      valid <= 1'b0;
    end else begin
      state <= next_state;
      hold_cnt <= next_hold_cnt;
      strap <= next_strap;
      valid <= next_valid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Boot decode
  sbs_pkg::sbs_boot_t boot_dec; // Decoded from held bits

  sbs_boot_decode u_decode (
    .i_strap(strap),
    .i_policy(i_boot_log_policy_fuse),
    .o_boot(boot_dec)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Output stage
  logic running; // Pins belong to their ordinary functions
  logic next_print_out;
  logic next_print_oe;
  logic next_boot_out;
  logic next_boot_oe;
  logic next_pull_up;
  logic [1:0] next_func_in;
  sbs_pkg::sbs_strap_t next_capture;
  sbs_pkg::sbs_boot_t next_boot;

  assign running = (state == sbs_pkg::ST_RUN);

  // Pin drive, status field and decoded boot choices
  always_comb begin
    next_print_out = sbs_pkg::PIN_RESET;
    next_print_oe = sbs_pkg::PIN_RESET;
    next_boot_out = sbs_pkg::PIN_RESET;
    next_boot_oe = sbs_pkg::PIN_RESET;
    next_pull_up = sbs_pkg::PULL_UP_RESET;
    next_func_in = '0;
    next_capture = strap;
    next_boot = '0;
    if (running) begin
      // Ordinary functions own the pins
      next_print_out = i_func_out[sbs_pkg::STRAP_PRINT_BIT];
      next_print_oe = i_func_oe[sbs_pkg::STRAP_PRINT_BIT];
      next_boot_out = i_func_out[sbs_pkg::STRAP_BOOT_BIT];
      next_boot_oe = i_func_oe[sbs_pkg::STRAP_BOOT_BIT];
      next_pull_up = i_func_boot_pull_up;
      next_func_in[sbs_pkg::STRAP_PRINT_BIT] = print_level;
      next_func_in[sbs_pkg::STRAP_BOOT_BIT] = boot_level;
    end
    if (valid) begin
      next_boot = boot_dec;
    end
  end

  // Output registers
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_print_select_strap_pin_out <= sbs_pkg::PIN_RESET;
      o_print_select_strap_pin_oe <= sbs_pkg::PIN_RESET;
      o_boot_select_strap_pin_out <= sbs_pkg::PIN_RESET;
      o_boot_select_strap_pin_oe <= sbs_pkg::PIN_RESET;
      o_boot_select_pull_up <= sbs_pkg::PULL_UP_RESET;
      o_func_in <= '0;
      o_chip_on <= 1'b0;
      o_pins_released <= 1'b0;
      o_strap_valid <= 1'b0;
      o_strap_capture_register <= sbs_pkg::STRAP_RESET;
      o_boot <= '0;
    end else begin
      o_print_select_strap_pin_out <= next_print_out;
      o_print_select_strap_pin_oe <= next_print_oe;
      o_boot_select_strap_pin_out <= next_boot_out;
      o_boot_select_strap_pin_oe <= next_boot_oe;
      o_boot_select_pull_up <= next_pull_up;
      o_func_in <= next_func_in;
      o_chip_on <= (state != sbs_pkg::ST_OFF);
      o_pins_released <= running;
      o_strap_valid <= valid;
      o_strap_capture_register <= next_capture;
      o_boot <= next_boot;
    end
  end

endmodule

// ### tb/sbs_props.sv
// Concurrent checks on the strap latch top-level ports.
// Assumes one clock domain and the synchronous active-low reset.
`timescale 1ns/1ps
module sbs_props (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_chip_enable,
  input wire sbs_pkg::sbs_reset_cause_t i_reset_cause,
  input wire logic [1:0] i_boot_log_policy_fuse,
  input wire logic i_print_select_strap_pin_in,
  input wire logic i_boot_select_strap_pin_in,
  input wire logic [1:0] i_func_out,
  input wire logic [1:0] i_func_oe,
  input wire logic o_print_select_strap_pin_out,
  input wire logic o_boot_select_strap_pin_out,
  input wire logic o_print_select_strap_pin_oe,
  input wire logic o_boot_select_strap_pin_oe,
  input wire logic o_boot_select_pull_up,
  input wire logic o_chip_on,
  input wire logic o_pins_released,
  input wire logic o_strap_valid,
  input wire sbs_pkg::sbs_strap_t o_strap_capture_register,
  input wire sbs_pkg::sbs_boot_t o_boot
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  ////////////////////////////////////////////////////////////////////////////
  // Running with the enable pin steadily high
  sequence s_steady;
    i_chip_enable [*5] ##0 o_pins_released;
  endsequence
  AST_FLASH: assert property (o_strap_valid |->
    o_boot.flash_boot == o_strap_capture_register.boot_select)
    else $error("flash boot not following boot strap");
  AST_DOWNLOAD: assert property (o_strap_valid |-> o_boot.download_boot ==
    (!o_strap_capture_register.boot_select && o_strap_capture_register.print_select))
    else $error("download boot decode wrong");
  AST_INVALID: assert property (o_strap_valid |-> o_boot.invalid ==
    (!o_strap_capture_register.boot_select && !o_strap_capture_register.print_select))
    else $error("invalid strap flag wrong");
  AST_LOG0: assert property (o_strap_valid && $past(i_boot_log_policy_fuse) == 2'h0
    |-> o_boot.log_enable) else $error("policy 0 not printing");
  AST_LOG1: assert property (o_strap_valid && $past(i_boot_log_policy_fuse) == 2'h1
    |-> o_boot.log_enable == !o_strap_capture_register.print_select)
    else $error("policy 1 print wrong");
  AST_LOG2: assert property (o_strap_valid && $past(i_boot_log_policy_fuse) == 2'h2
    |-> o_boot.log_enable == o_strap_capture_register.print_select)
    else $error("policy 2 print wrong");
  AST_LOG3: assert property (o_strap_valid && $past(i_boot_log_policy_fuse) == 2'h3
    |-> !o_boot.log_enable) else $error("policy 3 printing");
  AST_HELD: assert property ($past(o_pins_released) && o_pins_released
    |-> $stable(o_strap_capture_register)) else $error("held straps moved");
  AST_CAPTURE: assert property ($rose(o_pins_released) |-> o_strap_capture_register ==
    {$past(i_boot_select_strap_pin_in, 5), $past(i_print_select_strap_pin_in, 5)})
    else $error("captured straps differ from pins");
  AST_RESAMPLE: assert property (s_steady ##0 i_reset_cause[3:1] != 3'h0
    |-> ##2 !o_pins_released) else $error("resample reset ignored");
  AST_OTHER: assert property (s_steady ##0 i_reset_cause == 4'h1
    |=> o_pins_released) else $error("other reset resampled");
  AST_PULL: assert property (!o_pins_released |-> o_boot_select_pull_up)
    else $error("pull-up off before release");
  AST_FUNC: assert property ({o_boot_select_strap_pin_oe, o_print_select_strap_pin_oe}
    == (o_pins_released ? $past(i_func_oe) : 2'h0)) else $error("pin drive wrong");
  AST_PIN_OUT: assert property ({o_boot_select_strap_pin_out, o_print_select_strap_pin_out}
    == (o_pins_released ? $past(i_func_out) : 2'h0)) else $error("pin level wrong");
  AST_OFF: assert property (!$past(o_chip_on) && !o_chip_on
    |-> !o_strap_valid && o_strap_capture_register == 2'h0) else $error("off not cleared");
endmodule
bind sbs_strap_latch sbs_props sbs_props_i (.*);

// ### tb/sbs_host_model.sv
// Host and board side of the strap pins and the enable pin.
// Released lines without a pull show a pattern that changes every cycle.
`timescale 1ns/1ps
module sbs_host_model (
  input wire logic i_clk,
  input wire logic i_on,
  input wire logic [1:0] i_drive,
  input wire logic [1:0] i_level,
  input wire logic i_print_out,
  input wire logic i_print_oe,
  input wire logic i_boot_out,
  input wire logic i_boot_oe,
  input wire logic i_pull_up,
  output logic o_chip_enable,
  output logic o_print_pin,
  output logic o_boot_pin
);
  logic tog = 1'b0; // Floating line pattern
  // Toggle every cycle
  always @(posedge i_clk) tog <= !tog;
  // Wire resolution: device, host, pull, float
  always_comb begin
    o_chip_enable = i_on;
    o_print_pin = i_print_oe ? i_print_out : (i_drive[0] ? i_level[0] : tog);
    o_boot_pin = i_boot_oe ? i_boot_out : (i_drive[1] ? i_level[1] : (i_pull_up ? 1'b1 : tog));
  end
endmodule

// ### tb/sbs_strap_latch_tb.sv
// Self-checking bench for the strap latch and boot selector.
// Host model drives the pins; short hold count for speed.
`timescale 1ns/1ps
module sbs_strap_latch_tb;
  logic i_clk = 1'b0; // Core clock
  logic i_reset_n = 1'b0; // Power loss
  logic on = 1'b0; // Host enable request
  logic [1:0] drv = 2'h0; // Host drives, bit1 boot pin
  logic [1:0] lvl = 2'h0; // Host levels
  sbs_pkg::sbs_reset_cause_t cause = '0;
  logic [1:0] fuse = 2'h0;
  logic [1:0] f_out = 2'h0;
  logic [1:0] f_oe = 2'h0;
  logic f_pu = 1'b1;
  wire en, pin_p, pin_b, po, poe, bo, boe, pu, chip_on, rel, vld;
  wire sbs_pkg::sbs_strap_t cap;
  wire sbs_pkg::sbs_boot_t boot;
  int err_total = 0;
  int checks_done = 0;
  int cyc = 0;
  initial forever #25 i_clk = !i_clk;
  sbs_host_model sbs_host_model_i (.i_clk(i_clk), .i_on(on), .i_drive(drv), .i_level(lvl),
    .i_print_out(po), .i_print_oe(poe), .i_boot_out(bo), .i_boot_oe(boe), .i_pull_up(pu),
    .o_chip_enable(en), .o_print_pin(pin_p), .o_boot_pin(pin_b));
  sbs_strap_latch #(.HOLD_CYCLES(8)) sbs_strap_latch_i (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_chip_enable(en), .i_reset_cause(cause), .i_boot_log_policy_fuse(fuse),
    .i_print_select_strap_pin_in(pin_p), .i_boot_select_strap_pin_in(pin_b),
    .i_func_out(f_out), .i_func_oe(f_oe), .i_func_boot_pull_up(f_pu),
    .o_print_select_strap_pin_out(po), .o_print_select_strap_pin_oe(poe),
    .o_boot_select_strap_pin_out(bo), .o_boot_select_strap_pin_oe(boe),
    .o_boot_select_pull_up(pu), .o_func_in(), .o_chip_on(chip_on), .o_pins_released(rel),
    .o_strap_valid(vld), .o_strap_capture_register(cap), .o_boot(boot));
  ////////////////////////////////////////////////////////////////////////////
  // Expected boot choices from straps and policy
  function automatic sbs_pkg::sbs_boot_t exp_boot(input logic [1:0] s, input logic [1:0] f);
    logic lg;
    lg = (f == 2'h0) | (f == 2'h1 & !s[0]) | (f == 2'h2 & s[0]);
    return {s[1], !s[1] & s[0], !s[1] & !s[0], lg};
  endfunction
  // Advance n edges, then a fixed drive delay
  task automatic step(input int n);
    repeat (n) @(posedge i_clk);
    #5;
  endtask
  task automatic chk_strap(input sbs_pkg::sbs_strap_t e);
    checks_done++;
    if (cap !== e) begin
      err_total++;
      $display("mismatch strap exp %h got %h", e, cap);
    end
  endtask
  task automatic chk_boot(input sbs_pkg::sbs_boot_t e);
    checks_done++;
    if (boot !== e) begin
      err_total++;
      $display("mismatch boot exp %h got %h", e, boot);
    end
  endtask
  task automatic chk_bit(input string n, input logic e, input logic g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s exp %b got %b", n, e, g);
    end
  endtask
  // Bounded wait for pin release
  task automatic wait_rel();
    for (int k = 0; k < 40 && rel !== 1'b1; k++) step(1);
    chk_bit("released", 1'b1, rel);
  endtask
  // Power on with host strapping, release pins after capture
  task automatic power_up(input logic [1:0] d, input logic [1:0] l);
    drv = d;
    lvl = l;
    on = 1'b1;
    wait_rel();
    drv = 2'h0;
    step(2);
  endtask
  task automatic finish_test();
    if (err_total == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Hang guard
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      finish_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [1:0] v;
    void'($urandom(32'hB779));
    step(20);
    i_reset_n = 1'b1;
    step(2);
    // Every valid strap pair under every policy, then shutdown
    for (int c = 1; c < 4; c++) begin
      power_up(2'h3, c[1:0]);
      chk_strap(c[1:0]);
      for (int f = 0; f < 4; f++) begin
        fuse = f[1:0];
        step(2);
        chk_boot(exp_boot(c[1:0], f[1:0]));
      end
      on = 1'b0;
      step(10);
      chk_bit("valid", 1'b0, vld);
      chk_bit("chip_on", 1'b0, chip_on);
    end
    // Boot pin left open
    power_up(2'h1, 2'h1);
    chk_strap(2'h3);
    // Random functional pin traffic
    for (int k = 0; k < 30; k++) begin
      f_out = 2'($urandom);
      f_oe = 2'($urandom);
      f_pu = 1'($urandom);
      step(1);
    end
    f_oe = 2'h0;
    f_pu = 1'b1;
    step(2);
    chk_strap(2'h3);
    // Non-qualifying reset
    cause = 4'h1;
    step(1);
    cause = '0;
    step(6);
    chk_bit("released", 1'b1, rel);
    chk_strap(2'h3);
    // Brownout, watchdog, power-on resample with new levels
    for (int r = 1; r < 4; r++) begin
      v = 2'($urandom_range(3, 1));
      fuse = 2'($urandom);
      drv = 2'h3;
      lvl = v;
      step(2);
      cause = 4'h1 << r;
      step(1);
      cause = '0;
      step(2);
      wait_rel();
      drv = 2'h0;
      step(2);
      chk_strap(v);
      chk_boot(exp_boot(v, fuse));
    end
    finish_test();
  end
endmodule
